// File: verification/csfu_vec_model.sv
// restart vector memory model on the far side of the vector read port
`timescale 1ns/1ns
module csfu_vec_model #(
	parameter logic [15:0] WSP_VAL = 16'ha000,
	parameter logic [15:0] NIP_VAL = 16'hb000
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        vec_rd,
	input  wire logic [15:0] vec_addr,
	output logic [15:0]      vec_rdata,
	output logic             vec_ack
);
	logic [1:0] wait_cnt;
	// base pointer word answers slowly, pointer word at once
	always_ff @(posedge aclk) begin
		vec_ack <= 1'b0;
		vec_rdata <= ~vec_rdata; // data not held outside an answer
		if (!aresetn) begin
			wait_cnt <= 2'h0;
			vec_rdata <= 16'h0000;
		end else if (vec_rd && !vec_ack) begin
			if (wait_cnt >= (vec_addr[1] ? 2'h0 : 2'h3)) begin
				vec_ack <= 1'b1;
				vec_rdata <= (vec_addr == 16'hfffc) ? WSP_VAL : NIP_VAL;
				wait_cnt <= 2'h0;
			end else begin
				wait_cnt <= wait_cnt + 2'h1;
			end
		end
	end
endmodule : csfu_vec_model

// File: verification/test_cpu_status_flag_unit.sv
// self-checking testbench of the status flag unit
`timescale 1ns/1ns
module test_cpu_status_flag_unit;
	import csfu_pkg::*;
	// ==================================================================
	// stimulus and observed signals
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, fetch_valid = 0, exe_valid = 0, exe_byte = 0;
	logic mem_valid = 0, mem_write = 0, mem_word = 0, restart_req = 0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hf, exe_count = 4'h0, ws_index = 4'h0;
	logic [1:0]  fetch_words = 2'h1;
	csfu_op_e    exe_op = OP_CMP;
	logic [15:0] exe_src = 16'h0000, exe_dst = 16'h0000, exe_low = 16'h0000, mem_addr = 16'h0000;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exe_done;
	logic mem_chk_valid, mem_map_sel, mem_allow, vec_rd, vec_ack;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd;
	logic [15:0] exe_result, ws_addr, vec_addr, vec_rdata, next_instruction_pointer;
	logic [15:0] register_file_base_pointer, condition_flags_word;
	int bad_count = 0;
	int n_checks = 0;
	int i;
	csfu_flag_unit u_dut (.*);
	csfu_vec_model u_vec (.*);
	always #5 aclk = ~aclk;
	// ==================================================================
	// shared tasks
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (i = 0; i < 50 && !(s_axi_bvalid && s_axi_bready); i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 50) begin
			bad_count++;
			conclude();
		end
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (i = 0; i < 50 && !(s_axi_rvalid && s_axi_rready); i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		{rd, resp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		if (i == 50) begin
			bad_count++;
			conclude();
		end
	endtask : axi_rd
	// one operation, then the masked flag bits 15:9 against the expectation
	task ex(input csfu_op_e op, input logic b, input logic [15:0] s, d,
		input logic [3:0] c, input logic [6:0] m, e);
		@(posedge aclk);
		exe_op <= op;
		{exe_valid, exe_byte, exe_src, exe_dst, exe_count} <= {1'b1, b, s, d, c};
		@(posedge aclk);
		exe_valid <= 1'b0;
		#1;
		chk("exe_done", exe_done, 1'b1);
		chk("flags", condition_flags_word[15:9] & m, e);
	endtask : ex
	task mem(input logic [15:0] a, input logic w, wd, sel, ok);
		@(posedge aclk);
		{mem_valid, mem_addr, mem_write, mem_word} <= {1'b1, a, w, wd};
		@(posedge aclk);
		mem_valid <= 1'b0;
		#1;
		chk("mem", {mem_chk_valid, mem_map_sel, mem_allow}, {1'b1, sel, ok});
	endtask : mem
	// ==================================================================
	// scenarios
	task test_regs;
		axi_rd(CSFU_ADDR_FLG);
		chk("flags rst", rd, 32'h0000_0000);
		axi_rd(8'h14);
		chk("unmapped rresp", resp, 2'h2);
		chk("unmapped rd", rd, 32'h0000_0000);
		axi_wr(8'h14, 32'h0000_1234);
		chk("unmapped wr", resp, 2'h2);
		axi_wr(CSFU_ADDR_NIP, 32'h0000_0100);
		for (int w = 1; w <= 3; w++) begin
			@(posedge aclk);
			{fetch_valid, fetch_words} <= {1'b1, 2'(w)};
		end
		@(posedge aclk);
		fetch_valid <= 1'b0;
		#1;
		chk("pointer", next_instruction_pointer, 16'h010c);
		axi_wr(CSFU_ADDR_WSP, 32'h0000_2000);
		ws_index <= 4'hf;
		repeat (2) @(posedge aclk);
		#1;
		chk("ws_addr", ws_addr, 16'h201e);
		$display("test_regs done");
	endtask : test_regs
	task test_flags;
		ex(OP_ADD, 0, 16'h7fff, 16'h0001, 0, 7'h7c, 7'h44);
		ex(OP_ADD, 0, 16'hffff, 16'h0001, 0, 7'h7c, 7'h18);
		ex(OP_SUB, 0, 16'h0001, 16'h8000, 0, 7'h74, 7'h64);
		ex(OP_CMP, 0, 16'h0001, 16'hffff, 0, 7'h70, 7'h20);
		ex(OP_CMP, 1, 16'h8000, 16'h7f00, 0, 7'h72, 7'h42);
		ex(OP_SERIAL, 1, 16'h0000, 16'h0000, 9, 7'h02, 7'h02);
		ex(OP_SERIAL, 1, 16'h0000, 16'h0000, 8, 7'h02, 7'h00);
		ex(OP_DIV, 0, 16'h0005, 16'h0005, 0, 7'h04, 7'h04);
		ex(OP_MOVE, 0, 16'h0001, 16'h0001, 0, 7'h04, 7'h04);
		ex(OP_DIV, 0, 16'h0005, 16'h0004, 0, 7'h04, 7'h00);
		chk("quotient", exe_result, 16'hcccc);
		ex(OP_SLA, 0, 16'h4000, 16'h4000, 2, 7'h0c, 7'h0c);
		ex(OP_SLA, 0, 16'hc000, 16'hc000, 1, 7'h0c, 7'h08);
		ex(OP_SRL, 0, 16'h0001, 16'h0001, 1, 7'h18, 7'h18);
		ex(OP_SRA, 0, 16'h8001, 16'h8001, 1, 7'h68, 7'h48);
		ex(OP_SRC, 0, 16'h0001, 16'h0001, 1, 7'h68, 7'h48);
		ex(OP_ABS, 0, 16'h8000, 16'h8000, 0, 7'h04, 7'h04);
		ex(OP_NEG, 0, 16'h0001, 16'h0001, 0, 7'h04, 7'h00);
		ex(OP_NEG, 0, 16'h8000, 16'h8000, 0, 7'h04, 7'h04);
		ex(OP_XOP, 0, 16'h0000, 16'h0000, 0, 7'h01, 7'h01);
		ex(OP_LIMI, 0, 16'h000a, 16'h0000, 0, 7'h01, 7'h01);
		axi_rd(CSFU_ADDR_FLG);
		chk("level", rd[3:0], 4'ha);
		$display("test_flags done");
	endtask : test_flags
	task test_mem;
		axi_wr(CSFU_ADDR_CTL, 32'h0000_0001);
		mem(16'h0080, 0, 1, 1, 1);
		mem(16'h009e, 0, 1, 1, 1);
		mem(16'h00a0, 0, 1, 0, 1);
		axi_wr(CSFU_ADDR_CTL, 32'h0000_0000);
		mem(16'h0080, 0, 1, 0, 1);
		mem(16'h2001, 0, 1, 0, 0);
		mem(16'h2001, 0, 0, 0, 1);
		mem(16'h0ffe, 1, 1, 0, 0);
		mem(16'h1000, 1, 1, 0, 1);
		axi_rd(CSFU_ADDR_ERR);
		chk("errors", rd, 32'h0000_0003);
		axi_wr(CSFU_ADDR_ERR, 32'h0000_0003);
		axi_rd(CSFU_ADDR_ERR);
		chk("errors clr", rd, 32'h0000_0000);
		$display("test_mem done");
	endtask : test_mem
	task test_restart;
		@(posedge aclk);
		restart_req <= 1'b1;
		@(posedge aclk);
		restart_req <= 1'b0;
		for (i = 0; i < 100 && next_instruction_pointer !== 16'hb000; i++) @(posedge aclk);
		#1;
		chk("restart wsp", register_file_base_pointer, 16'ha000);
		chk("restart nip", {next_instruction_pointer, vec_rd}, {16'hb000, 1'b0});
		$display("test_restart done");
		if (i == 100) begin
			bad_count++;
			conclude();
		end
	endtask : test_restart
	// ==================================================================
	// main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_regs();
		test_flags();
		test_mem();
		test_restart();
		conclude();
	end
endmodule : test_cpu_status_flag_unit

// File: verilog/csfu_flag_unit.sv
// status flag unit: pointers, condition flags, memory decode, register slave
//
// Summary of operation
// (RULE_01) after an instruction fetch the pointer steps two bytes per instruction word
// (RULE_02) base pointer addresses register 0 of sixteen consecutive register words
// (RULE_03) unsigned greater compares magnitudes, top bit weighs 128 or 32768
// (RULE_04) signed greater compares two's complement values, top bit is the sign
// (RULE_05) same value flag set exactly when both operands are identical
// (RULE_06) arithmetic carry is the carry out of the sign bit
// (RULE_07) shifts leave the last bit shifted out in carry
// (RULE_08) add overflow: equal operand signs, result sign differs from destination
// (RULE_09) subtract overflow: differing operand signs, result sign differs from destination
// (RULE_10) divide overflow when upper dividend half is at least the divisor
// (RULE_11) left arithmetic shift overflow when the top bit ever changes
// (RULE_12) magnitude and negation overflow when source is the most negative word
// (RULE_13) byte operations set parity bit for an odd count of ones
// (RULE_14) soft trap call sets the extended operation bit
// (RULE_15) flags word holds the lowest accepted interrupt level
// (RULE_16) restart vectors come from words fffc and fffe in writable memory
// (RULE_17) 0080 to 009f select mapper registers only in register mode
// (RULE_18) word accesses must use even byte addresses
// (RULE_19) program memory is never written; workspaces sit in writable memory
// (RULE_20) serial transfers of eight bits or fewer update parity, others keep it
// (RULE_21) flags an operation does not define keep their value
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module csfu_flag_unit #(
	parameter int ADDR_W = 8,
	parameter logic [15:0] ROM_TOP = 16'h1000 // first byte above program memory
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 fetch_valid,
	input  wire logic [1:0]           fetch_words,
	input  wire logic                 exe_valid,
	input  wire csfu_pkg::csfu_op_e   exe_op,
	input  wire logic                 exe_byte,
	input  wire logic [15:0]          exe_src,
	input  wire logic [15:0]          exe_dst,
	input  wire logic [15:0]          exe_low,
	input  wire logic [3:0]           exe_count,
	output logic                      exe_done,
	output logic [15:0]               exe_result,
	input  wire logic [3:0]           ws_index,
	output logic [15:0]               ws_addr,
	input  wire logic                 mem_valid,
	input  wire logic [15:0]          mem_addr,
	input  wire logic                 mem_write,
	input  wire logic                 mem_word,
	output logic                      mem_chk_valid,
	output logic                      mem_map_sel,
	output logic                      mem_allow,
	input  wire logic                 restart_req,
	output logic                      vec_rd,
	output logic [15:0]               vec_addr,
	input  wire logic [15:0]          vec_rdata,
	input  wire logic                 vec_ack,
	output logic [15:0]               next_instruction_pointer,
	output logic [15:0]               register_file_base_pointer,
	output logic [15:0]               condition_flags_word
);
	import csfu_pkg::*;

	if (ADDR_W < 5) begin : g_chk
		$error("csfu_flag_unit: ADDR_W too small for the register map");
	end
	if (ROM_TOP > CSFU_VEC_WSP) begin : g_chk_rom
		$error("csfu_flag_unit: restart vectors must lie in writable memory");
	end

	// ==================================================================
	// functions
	// merge the low two byte lanes of a bus write into a 16 bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// operation result and flags {lgt, agt, eq, cy, ov, op, x, result}
	function automatic logic [22:0] exec_op(input csfu_op_e op, input logic bm,
		input logic [15:0] s, input logic [15:0] d, input logic [15:0] lo,
		input logic [4:0] cnt, input logic [6:0] old);
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] r;
		logic [16:0] sum;
		logic [31:0] q;
		logic        lgt, agt, eq, cy, ov, par, x, zcmp, pb;
		a = bm ? {s[15:8], 8'h00} : s; // byte operands sit at the sign end
		b = bm ? {d[15:8], 8'h00} : d;
		r = b;
		sum = 17'h0_0000;
		q = 32'h0000_0000;
		{lgt, agt, eq, cy, ov, par, x} = old; // RULE_21
		zcmp = 1'b1;
		pb = bm;
		case (op)
			OP_CMP: begin
				lgt = a > b; // RULE_03
				agt = $signed(a) > $signed(b); // RULE_04
				eq = a == b; // RULE_05
				r = a;
				zcmp = 1'b0;
			end
			OP_ADD: begin
				sum = {1'b0, b} + {1'b0, a};
				r = sum[15:0];
				cy = sum[16]; // RULE_06
				ov = (a[15] == b[15]) && (r[15] != b[15]); // RULE_08
			end
			OP_SUB: begin
				sum = {1'b0, b} + {1'b0, ~a} + 17'h0_0001;
				r = sum[15:0];
				cy = sum[16]; // RULE_06
				ov = (a[15] != b[15]) && (r[15] != b[15]); // RULE_09
			end
			OP_DIV: begin
				ov = d >= s; // RULE_10
				if (!ov) begin
					q = {d, lo} / {16'h0000, s};
					r = q[15:0];
				end
				zcmp = 1'b0;
				pb = 1'b0;
			end
			OP_SLA, OP_SRA, OP_SRL, OP_SRC: begin
				if (op == OP_SLA) begin
					ov = 1'b0;
				end
				for (int i = 0; i < 16; i++) begin
					if (i < int'(cnt)) begin
						case (op)
							OP_SLA: begin
								cy = r[15]; // RULE_07
								if (r[14] != r[15]) begin
									ov = 1'b1; // RULE_11
								end
								r = {r[14:0], 1'b0};
							end
							OP_SRA: begin
								cy = r[0]; // RULE_07
								r = {r[15], r[15:1]};
							end
							OP_SRL: begin
								cy = r[0]; // RULE_07
								r = {1'b0, r[15:1]};
							end
							default: begin
								cy = r[0]; // RULE_07
								r = {r[0], r[15:1]};
							end
						endcase
					end
				end
				pb = 1'b0;
			end
			OP_ABS, OP_NEG: begin
				sum = {1'b0, ~s} + 17'h0_0001;
				r = (op == OP_NEG || s[15]) ? sum[15:0] : s;
				cy = sum[16];
				ov = s == 16'h8000; // RULE_12
				pb = 1'b0;
			end
			OP_MOVE: r = a;
			OP_SERIAL: begin
				r = a;
				pb = cnt <= 5'h08; // RULE_20
			end
			OP_XOP: begin
				x = 1'b1; // RULE_14
				zcmp = 1'b0;
				pb = 1'b0;
			end
			default: begin
				zcmp = 1'b0;
				pb = 1'b0;
			end
		endcase
		if (zcmp) begin
			lgt = r != 16'h0000;
			agt = !r[15] && (r != 16'h0000);
			eq = r == 16'h0000;
		end
		if (pb) begin
			par = ^r[15:8]; // RULE_13
		end
		if (bm && op != OP_CMP) begin
			r = {r[15:8], d[7:0]};
		end
		exec_op = {lgt, agt, eq, cy, ov, par, x, r};
	endfunction : exec_op

	// ==================================================================
	// registers
	logic [15:0]       nip_reg, nip_next;
	logic [15:0]       wsp_reg, wsp_next;
	logic [15:0]       flg_reg, flg_next;
	logic              ctl_reg, ctl_next;
	logic [1:0]        err_reg, err_next;
	logic              aw_held_reg, w_held_reg;
	logic [ADDR_W-1:0] waddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0]        bresp_reg, rresp_reg;
	logic [31:0]       rdata_reg, rdata_next;
	logic              done_reg;
	logic [15:0]       result_reg, wsa_reg, vaddr_reg;
	logic              mchk_reg, msel_reg, mallow_reg, vrd_reg;
	csfu_vec_e         vec_reg, vec_next;

	// ==================================================================
	// register bus decode
	wire aw_take  = s_axi_awvalid && awready_reg;
	wire w_take   = s_axi_wvalid && wready_reg;
	wire wr_fire  = aw_held_reg && w_held_reg && !bvalid_reg;
	wire ar_take  = s_axi_arvalid && arready_reg;
	wire aw_h_nx  = (aw_held_reg && !wr_fire) || aw_take;
	wire w_h_nx   = (w_held_reg && !wr_fire) || w_take;
	wire rv_nx    = ar_take || (rvalid_reg && !s_axi_rready);
	wire [7:0] wa = 8'(waddr_reg);
	wire [7:0] ra = 8'(s_axi_araddr);
	wire wa_ok    = wa == CSFU_ADDR_NIP || wa == CSFU_ADDR_WSP || wa == CSFU_ADDR_FLG
		|| wa == CSFU_ADDR_CTL || wa == CSFU_ADDR_ERR;
	wire ra_ok    = ra == CSFU_ADDR_NIP || ra == CSFU_ADDR_WSP || ra == CSFU_ADDR_FLG
		|| ra == CSFU_ADDR_CTL || ra == CSFU_ADDR_ERR;
	wire wr_nip   = wr_fire && wa == CSFU_ADDR_NIP;
	wire wr_wsp   = wr_fire && wa == CSFU_ADDR_WSP;
	wire wr_flg   = wr_fire && wa == CSFU_ADDR_FLG;
	wire wr_ctl   = wr_fire && wa == CSFU_ADDR_CTL && wstrb_reg[0];
	wire wr_err   = wr_fire && wa == CSFU_ADDR_ERR && wstrb_reg[0];
	assign rdata_next = (ra == CSFU_ADDR_NIP) ? {16'h0000, nip_reg}
		: (ra == CSFU_ADDR_WSP) ? {16'h0000, wsp_reg}
		: (ra == CSFU_ADDR_FLG) ? {16'h0000, flg_reg}
		: (ra == CSFU_ADDR_CTL) ? {31'h0000_0000, ctl_reg}
		: (ra == CSFU_ADDR_ERR) ? {30'h0000_0000, err_reg} : 32'h0000_0000;

	// execution results and flag update
	wire [4:0]  cnt5    = (exe_count == 4'h0) ? 5'h10 : {1'b0, exe_count};
	wire [6:0]  old_f   = flg_reg[CSFU_ST_LGT:CSFU_ST_X];
	wire        eff_b   = exe_byte && exe_op != OP_DIV;
	wire [22:0] ex_out  = exec_op(exe_op, eff_b, exe_src, exe_dst, exe_low, cnt5, old_f);
	wire [15:0] flg_ex  = (exe_op == OP_LIMI)
		? {flg_reg[15:4], exe_src[3:0]} // RULE_15
		: {ex_out[22:16], flg_reg[8:0]};
	assign flg_next = (exe_valid) ? flg_ex
		: wr_flg ? merge16(flg_reg, wdata_reg, wstrb_reg) : flg_reg;

	// memory region decode
	wire in_map   = mem_addr >= CSFU_MAP_LO && mem_addr <= CSFU_MAP_HI;
	wire odd_word = mem_word && mem_addr[0]; // RULE_18
	wire rom_wr   = mem_write && mem_addr < ROM_TOP; // RULE_19
	wire map_sel  = in_map && ctl_reg; // RULE_17

	// restart vector sequence and pointer updates
	wire [15:0] step = {13'h0000, fetch_words, 1'b0}; // RULE_01
	always_comb begin
		vec_next = vec_reg;
		case (vec_reg)
			VEC_IDLE: if (restart_req) vec_next = VEC_WSP;
			VEC_WSP:  if (vec_ack) vec_next = VEC_NIP;
			VEC_NIP:  if (vec_ack) vec_next = VEC_IDLE;
			default:  vec_next = VEC_IDLE;
		endcase
	end
	assign wsp_next = (vec_reg == VEC_WSP && vec_ack) ? vec_rdata
		: wr_wsp ? merge16(wsp_reg, wdata_reg, wstrb_reg) : wsp_reg;
	assign nip_next = (vec_reg == VEC_NIP && vec_ack) ? vec_rdata
		: fetch_valid ? 16'(nip_reg + step) // RULE_01
		: wr_nip ? merge16(nip_reg, wdata_reg, wstrb_reg) : nip_reg;
	assign ctl_next = wr_ctl ? wdata_reg[CSFU_CTL_MAPREG] : ctl_reg;
	// new errors win over a clear in the same cycle
	assign err_next = (wr_err ? (err_reg & ~wdata_reg[1:0]) : err_reg)
		| {mem_valid && rom_wr, mem_valid && odd_word};

	// ==================================================================
	// bus handshake flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'b00;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= 2'b00;
			rdata_reg   <= 32'h0000_0000;
			waddr_reg   <= '0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end else begin
			aw_held_reg <= aw_h_nx;
			w_held_reg  <= w_h_nx;
			awready_reg <= !aw_h_nx;
			wready_reg  <= !w_h_nx;
			bvalid_reg  <= wr_fire || (bvalid_reg && !s_axi_bready);
			if (wr_fire) bresp_reg <= wa_ok ? 2'b00 : 2'b10; // slverr when unmapped
			if (aw_take) waddr_reg <= s_axi_awaddr;
			if (w_take) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			rvalid_reg  <= rv_nx;
			arready_reg <= !rv_nx;
			if (ar_take) begin
				rdata_reg <= rdata_next;
				rresp_reg <= ra_ok ? 2'b00 : 2'b10;
			end
		end
	end

	// architectural registers and datapath outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nip_reg    <= CSFU_NIP_RST;
			wsp_reg    <= CSFU_WSP_RST;
			flg_reg    <= CSFU_FLG_RST;
			ctl_reg    <= 1'b0;
			err_reg    <= 2'b00;
			vec_reg    <= VEC_IDLE;
			done_reg   <= 1'b0;
			result_reg <= 16'h0000;
			wsa_reg    <= 16'h0000;
		end else begin
			nip_reg    <= nip_next;
			wsp_reg    <= wsp_next;
			flg_reg    <= flg_next;
			ctl_reg    <= ctl_next;
			err_reg    <= err_next;
			vec_reg    <= vec_next;
			done_reg   <= exe_valid;
			if (exe_valid) result_reg <= ex_out[15:0];
			wsa_reg    <= 16'(wsp_reg + {11'h000, ws_index, 1'b0}); // RULE_02
		end
	end

	// memory decode and vector fetch outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mchk_reg   <= 1'b0;
			msel_reg   <= 1'b0;
			mallow_reg <= 1'b0;
			vrd_reg    <= 1'b0;
			vaddr_reg  <= 16'h0000;
		end else begin
			mchk_reg   <= mem_valid;
			msel_reg   <= mem_valid && map_sel; // RULE_17
			mallow_reg <= mem_valid && !odd_word && !rom_wr; // RULE_18 RULE_19
			vrd_reg    <= vec_next != VEC_IDLE;
			vaddr_reg  <= (vec_next == VEC_NIP) ? CSFU_VEC_NIP : CSFU_VEC_WSP; // RULE_16
		end
	end

	// ==================================================================
	// output ports
	assign s_axi_awready              = awready_reg;
	assign s_axi_wready               = wready_reg;
	assign s_axi_bvalid               = bvalid_reg;
	assign s_axi_bresp                = bresp_reg;
	assign s_axi_arready              = arready_reg;
	assign s_axi_rvalid               = rvalid_reg;
	assign s_axi_rdata                = rdata_reg;
	assign s_axi_rresp                = rresp_reg;
	assign exe_done                   = done_reg;
	assign exe_result                 = result_reg;
	assign ws_addr                    = wsa_reg;
	assign mem_chk_valid              = mchk_reg;
	assign mem_map_sel                = msel_reg;
	assign mem_allow                  = mallow_reg;
	assign vec_rd                     = vrd_reg;
	assign vec_addr                   = vaddr_reg;
	assign next_instruction_pointer   = nip_reg;
	assign register_file_base_pointer = wsp_reg;
	assign condition_flags_word       = flg_reg;

	// ==================================================================
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire idle_v = vec_reg == VEC_IDLE;

	chk_fetch_step: assert property ( // RULE_01
		fetch_valid && idle_v |=> nip_reg == 16'($past(nip_reg) + {$past(fetch_words), 1'b0}))
		else $error("pointer did not advance by the fetched words");
	chk_ws_addr: assert property ( // RULE_02
		##1 wsa_reg == 16'($past(wsp_reg) + {$past(ws_index), 1'b0}))
		else $error("register address not base plus twice index");
	chk_lgt_cmp: assert property ( // RULE_03
		exe_valid && exe_op == OP_CMP && !exe_byte
		|=> flg_reg[CSFU_ST_LGT] == ($past(exe_src) > $past(exe_dst)))
		else $error("unsigned greater wrong");
	chk_agt_cmp: assert property ( // RULE_04
		exe_valid && exe_op == OP_CMP && !exe_byte
		|=> flg_reg[CSFU_ST_AGT] == ($signed($past(exe_src)) > $signed($past(exe_dst))))
		else $error("signed greater wrong");
	chk_eq_cmp: assert property ( // RULE_05
		exe_valid && exe_op == OP_CMP |=> flg_reg[CSFU_ST_EQ]
		== ($past(exe_byte) ? $past(exe_src[15:8]) == $past(exe_dst[15:8])
		: $past(exe_src) == $past(exe_dst)))
		else $error("same value flag wrong");
	chk_add_cy: assert property ( // RULE_06
		exe_valid && exe_op == OP_ADD && !exe_byte
		|=> flg_reg[CSFU_ST_CY] == ({1'b0, $past(exe_src)} + {1'b0, $past(exe_dst)} > 17'h0_ffff))
		else $error("add carry wrong");
	chk_div_ov: assert property ( // RULE_10
		exe_valid && exe_op == OP_DIV |=> flg_reg[CSFU_ST_OV] == ($past(exe_dst) >= $past(exe_src)))
		else $error("divide overflow wrong");
	chk_neg_ov: assert property ( // RULE_12
		exe_valid && exe_op == OP_NEG && exe_src == 16'h8000 |=> flg_reg[CSFU_ST_OV])
		else $error("negation of most negative did not overflow");
	chk_xop_set: assert property ( // RULE_14
		exe_valid && exe_op == OP_XOP |=> flg_reg[CSFU_ST_X] && exe_done)
		else $error("soft trap bit not set");
	chk_div_keep: assert property ( // RULE_21
		exe_valid && exe_op == OP_DIV |=> $stable(flg_reg[CSFU_ST_LGT:CSFU_ST_CY]))
		else $error("divide disturbed unrelated flags");
	chk_map_sel: assert property ( // RULE_17
		mem_valid && in_map && !ctl_reg |=> !msel_reg)
		else $error("mapper selected outside register mode");
	chk_odd_word: assert property ( // RULE_18
		mem_valid && mem_word && mem_addr[0] |=> !mallow_reg ##0 err_reg[CSFU_ERR_ALIGN])
		else $error("odd word access allowed");
	chk_vec_seq: assert property ( // RULE_16
		idle_v && restart_req |=> vrd_reg && vaddr_reg == CSFU_VEC_WSP)
		else $error("restart fetch not at fffc");

	cov_restart: cover property (vec_reg == VEC_NIP && vec_ack);
	cov_sla_ov: cover property (exe_valid && exe_op == OP_SLA ##1 flg_reg[CSFU_ST_OV]);
	cov_bus_wr: cover property (wr_fire && wa == CSFU_ADDR_FLG);
	cov_map: cover property (msel_reg);

endmodule : csfu_flag_unit

// File: verilog/csfu_pkg.sv
// constants, types and register map of the status flag unit
package csfu_pkg;

	// ==================================================================
	// register map (byte addresses on the register bus)
	localparam logic [7:0] CSFU_ADDR_NIP = 8'h00; // next instruction pointer
	localparam logic [7:0] CSFU_ADDR_WSP = 8'h04; // register file base pointer
	localparam logic [7:0] CSFU_ADDR_FLG = 8'h08; // condition flags word
	localparam logic [7:0] CSFU_ADDR_CTL = 8'h0c; // memory decode control
	localparam logic [7:0] CSFU_ADDR_ERR = 8'h10; // access error flags, write one to clear

	// ==================================================================
	// reset values
	localparam logic [15:0] CSFU_NIP_RST = 16'h0000;
	localparam logic [15:0] CSFU_WSP_RST = 16'h0000;
	localparam logic [15:0] CSFU_FLG_RST = 16'h0000;

	// ==================================================================
	// condition flags word fields
	localparam int CSFU_ST_LGT = 15; // unsigned greater
	localparam int CSFU_ST_AGT = 14; // signed greater
	localparam int CSFU_ST_EQ  = 13; // same value flag
	localparam int CSFU_ST_CY  = 12; // carry
	localparam int CSFU_ST_OV  = 11; // range error bit
	localparam int CSFU_ST_OP  = 10; // parity odd bit
	localparam int CSFU_ST_X   = 9;  // soft trap call in progress
	localparam int CSFU_ST_IM  = 0;  // interrupt level field, four bits

	// ==================================================================
	// control and error fields
	localparam int CSFU_CTL_MAPREG = 0; // mapper register mode
	localparam int CSFU_ERR_ALIGN  = 0; // odd word address seen
	localparam int CSFU_ERR_ROMWR  = 1; // write into program memory seen

	// ==================================================================
	// memory map figures
	localparam logic [15:0] CSFU_MAP_LO    = 16'h0080;
	localparam logic [15:0] CSFU_MAP_HI    = 16'h009f;
	localparam logic [15:0] CSFU_VEC_WSP   = 16'hfffc; // restart base pointer
	localparam logic [15:0] CSFU_VEC_NIP   = 16'hfffe; // restart instruction pointer
	localparam logic [15:0] CSFU_WORD_STEP = 16'h0002; // bytes per word

	// ==================================================================
	// operations presented by the execution datapath
	typedef enum logic [3:0] {
		OP_CMP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_DIV = 4'h3,
		OP_SLA = 4'h4, OP_SRA = 4'h5, OP_SRL = 4'h6, OP_SRC = 4'h7,
		OP_ABS = 4'h8, OP_NEG = 4'h9, OP_MOVE = 4'ha, OP_SERIAL = 4'hb,
		OP_XOP = 4'hc, OP_LIMI = 4'hd
	} csfu_op_e;

	// restart vector fetch sequence, gray coded except the NIP to IDLE step, which changes both bits
	typedef enum logic [1:0] {
		VEC_IDLE = 2'b00,
		VEC_WSP  = 2'b01,
		VEC_NIP  = 2'b11
	} csfu_vec_e;

endpackage : csfu_pkg
